// ==== mfg_pkg.sv ====
// Shared constants for the multi-function pin control block
package mfg_pkg;
	// Pin count and register width
	localparam int NUM_PINS = 5;
	localparam int CFG_W = 16;
	localparam int FN_W = 5;
	// Register indices; the bus byte address is four times the index
	localparam logic [15:0] IDX_PIN1 = 16'h0700;
	localparam logic [15:0] IDX_PIN8 = 16'h0707;
	localparam logic [15:0] IDX_PIN9 = 16'h0708;
	localparam logic [15:0] IDX_PIN10 = 16'h0709;
	localparam logic [15:0] IDX_PIN11 = 16'h070a;
	localparam logic [15:0] IDX_INT_STATUS = 16'h070b;
	localparam logic [15:0] IDX_INT_MASK = 16'h070c;
	localparam logic [1:0] IDX_SHIFT = 2'h2;
	// Field positions inside a pin configuration register
	localparam int BIT_DIR = 15;
	localparam int BIT_PU = 14;
	localparam int BIT_PD = 13;
	localparam int BIT_POL = 10;
	localparam int BIT_OD = 9;
	localparam int BIT_DB = 8;
	localparam int BIT_LVL = 6;
	localparam int FN_LSB = 0;
	// Writable bits and reset values
	localparam logic [15:0] CFG_WR_MASK = 16'he75f;
	localparam logic [15:0] CFG_RST_COMMON = 16'ha100;
	localparam logic [4:0] FN_RST_PIN1 = 5'h00;
	localparam logic [4:0] FN_RST_OTHER = 5'h01;
	// Function codes
	localparam logic [4:0] FN_ALT_AUDIO = 5'h00;
	localparam logic [4:0] FN_LOGIC = 5'h01;
	localparam logic [4:0] FN_IRQ = 5'h03;
	localparam logic [4:0] FN_TEMP_SHUT = 5'h04;
	localparam logic [4:0] FN_ACC_PULSE = 5'h05;
	localparam logic [4:0] FN_FLL1_LOCK = 5'h09;
	localparam logic [4:0] FN_FLL2_LOCK = 5'h0a;
	localparam logic [4:0] FN_SRC1_LOCK = 5'h0b;
	localparam logic [4:0] FN_SRC2_LOCK = 5'h0c;
	localparam logic [4:0] FN_DRC1_SIG = 5'h0d;
	localparam logic [4:0] FN_DRC2_SIG = 5'h0f;
	localparam logic [4:0] FN_FIFO_ERR = 5'h11;
	localparam logic [4:0] FN_OPCLK = 5'h12;
	localparam logic [4:0] FN_TEMP_WARN = 5'h13;
	localparam logic [4:0] FN_DCS_DONE = 5'h14;
	localparam logic [4:0] FN_FLL1_CLK = 5'h15;
	localparam logic [4:0] FN_FLL2_CLK = 5'h16;
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int PULSE_NS = 31000;
	localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;
	localparam int DEBOUNCE_NS = 100000;
	localparam int DEBOUNCE_CYC = DEBOUNCE_NS / CLK_PERIOD_NS;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mfg_pkg

// ==== mfg_pin_filter.sv ====
// Three-stage synchroniser and de-bounce filter for one pin input
`timescale 1ns/10ps
module mfg_pin_filter #(
	parameter int DB_CYCLES = 1000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw pin and control
	input wire logic raw_i,
	input wire logic db_en_i,
	// Accepted level
	output logic level_o
);
	localparam int CW = $clog2(DB_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(DB_CYCLES - 1);
	logic s1_reg; // First stage, read only by the second
	logic s2_reg; // Second stage
	logic s3_reg; // Third stage
	logic [CW-1:0] cnt_reg; // Stability counter

	// Synchroniser chain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= raw_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Accept a level once stages two and three agree, after the hold time if filtering
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_o <= 1'b0;
			cnt_reg <= '0;
		end else if (s2_reg != s3_reg || s3_reg == level_o) begin
			// Unsettled or unchanged: restart the count
			cnt_reg <= '0;
		end else if (!db_en_i || cnt_reg == CNT_LAST) begin
			// With filtering enabled, glitches shorter than the hold time never reach here
			level_o <= s3_reg;
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule : mfg_pin_filter

// ==== mfg_gpio_top.sv ====
// Five-pin multi-function pin controller with an AXI4-Lite register slave
// Function
// - Route each pin per its function field
// - Code 00h: alternate audio; pin1 record clock
// - Input level bit reads true pin level
// - Per-pin de-bounce filter, enabled at reset
// - Logic output drives the written level
// - Polarity bit inverts the selected output
// - Drive type: push-pull or open-drain
// - Pull enables; both set disables both
// - Both pin edges raise interrupt event
// - Interrupt flag latched, pollable, drives IRQ
// - Reset function codes: pin1 0, others 1
// - Code 05h: 31 us accessory pulse
// - Code 01h input acts as button input
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
module mfg_gpio_top
	import mfg_pkg::*;
#(
	parameter int DB_CYCLES = DEBOUNCE_CYC,
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	// AXI4-Lite write data
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	// AXI4-Lite write response
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	// AXI4-Lite read data
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	// Pins, index 0..4 = pins 1, 8, 9, 10, 11
	input wire logic [NUM_PINS-1:0] PIN_IN_I,
	output logic [NUM_PINS-1:0] PIN_OUT_O,
	output logic [NUM_PINS-1:0] PIN_OE_O,
	output logic [NUM_PINS-1:0] PULLUP_EN_O,
	output logic [NUM_PINS-1:0] PULLDOWN_EN_O,
	// Alternate audio interface signals
	input wire logic [NUM_PINS-1:0] ALT_AUDIO_OUT_I,
	output logic [NUM_PINS-1:0] ALT_AUDIO_IN_O,
	// Button or logic-level inputs, filtered
	output logic [NUM_PINS-1:0] BUTTON_LEVEL_O,
	// Internal status and clock sources
	input wire logic TEMP_SHUTDOWN_I,
	input wire logic ACCESSORY_EVENT_I,
	input wire logic FLL1_LOCK_I,
	input wire logic FLL2_LOCK_I,
	input wire logic SRC1_LOCK_I,
	input wire logic SRC2_LOCK_I,
	input wire logic DRC1_SIGNAL_I,
	input wire logic DRC2_SIGNAL_I,
	input wire logic FIFO_ERROR_I,
	input wire logic OPCLK_I,
	input wire logic TEMP_WARNING_I,
	input wire logic DC_SERVO_DONE_I,
	input wire logic FLL1_CLK_I,
	input wire logic FLL2_CLK_I,
	// Interrupt request
	output logic IRQ_O
);
	localparam int PW = $clog2(PULSE_CYC + 1);
	localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYC);
	localparam logic [ADDR_W-1:0] ADDR_PIN1 = ADDR_W'(IDX_PIN1) << IDX_SHIFT;
	localparam logic [ADDR_W-1:0] ADDR_PIN8 = ADDR_W'(IDX_PIN8) << IDX_SHIFT;
	localparam logic [ADDR_W-1:0] ADDR_PIN9 = ADDR_W'(IDX_PIN9) << IDX_SHIFT;
	localparam logic [ADDR_W-1:0] ADDR_PIN10 = ADDR_W'(IDX_PIN10) << IDX_SHIFT;
	localparam logic [ADDR_W-1:0] ADDR_PIN11 = ADDR_W'(IDX_PIN11) << IDX_SHIFT;
	localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = ADDR_W'(IDX_INT_STATUS) << IDX_SHIFT;
	localparam logic [ADDR_W-1:0] ADDR_INT_MASK = ADDR_W'(IDX_INT_MASK) << IDX_SHIFT;

	logic [CFG_W-1:0] cfg_reg [NUM_PINS]; // Pin configuration registers
	logic [NUM_PINS-1:0] int_status_reg; // Sticky edge flags
	logic [NUM_PINS-1:0] int_mask_reg; // Interrupt enables, 1 = pass
	logic [NUM_PINS-1:0] level_flt; // Filtered pin levels
	logic [NUM_PINS-1:0] level_prev_reg; // Previous filtered levels
	logic [NUM_PINS-1:0] edge_evt; // Edge events this cycle
	logic [PW-1:0] pulse_cnt_reg; // Accessory pulse timer
	logic acc_pulse; // Accessory pulse level
	logic irq_int; // Combined interrupt
	logic [NUM_PINS-1:0] out_val; // Selected output values
	// Write channel holding
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_fire; // Write performed this cycle
	logic [NUM_PINS-1:0] wr_pin_sel; // Pin register addressed by write
	logic wr_stat_sel; // Status register addressed by write
	logic wr_mask_sel; // Mask register addressed by write
	logic [15:0] wr_bits; // Byte-enabled write mask
	// Read path
	logic [31:0] rd_data; // Decoded read value
	logic rd_hit; // Read address mapped

	// Per-pin synchroniser and filter
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			mfg_pin_filter #(
				.DB_CYCLES(DB_CYCLES)
			) u_filter (
				.clk_i(CLOCK_I),
				.rst_i(RST_I),
				.raw_i(PIN_IN_I[gi]),
				.db_en_i(cfg_reg[gi][BIT_DB]),
				.level_o(level_flt[gi])
			);
		end
	endgenerate

	// Write decode: address and data may arrive in either order
	assign wr_fire = aw_held_reg && w_held_reg && !BVALID_O;
	assign wr_bits = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	always_comb begin
		wr_pin_sel = '0;
		wr_stat_sel = 1'b0;
		wr_mask_sel = 1'b0;
		unique case (awaddr_reg)
			ADDR_PIN1: wr_pin_sel[0] = 1'b1;
			ADDR_PIN8: wr_pin_sel[1] = 1'b1;
			ADDR_PIN9: wr_pin_sel[2] = 1'b1;
			ADDR_PIN10: wr_pin_sel[3] = 1'b1;
			ADDR_PIN11: wr_pin_sel[4] = 1'b1;
			ADDR_INT_STATUS: wr_stat_sel = 1'b1;
			ADDR_INT_MASK: wr_mask_sel = 1'b1;
			default: wr_stat_sel = 1'b0;
		endcase
	end

	// Write address and data capture
	assign AWREADY_O = !aw_held_reg;
	assign WREADY_O = !w_held_reg;
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (AWVALID_I && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= AWADDR_I;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (WVALID_I && !w_held_reg) begin
				w_held_reg <= 1'b1;
				wdata_reg <= WDATA_I;
				wstrb_reg <= WSTRB_I;
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response, error for unmapped addresses
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			BVALID_O <= 1'b0;
			BRESP_O <= RESP_OKAY;
		end else if (wr_fire) begin
			BVALID_O <= 1'b1;
			BRESP_O <= (|wr_pin_sel || wr_stat_sel || wr_mask_sel) ? RESP_OKAY : RESP_SLVERR;
		end else if (BREADY_I) begin
			BVALID_O <= 1'b0;
		end
	end

	// Configuration registers with per-pin reset function codes
	always_ff @(posedge CLOCK_I) begin
		for (int p = 0; p < NUM_PINS; p++) begin
			if (RST_I) begin
				cfg_reg[p] <= CFG_RST_COMMON;
				cfg_reg[p][FN_LSB +: FN_W] <= (p == 0) ? FN_RST_PIN1 : FN_RST_OTHER;
			end else if (wr_fire && wr_pin_sel[p]) begin
				cfg_reg[p] <= (cfg_reg[p] & ~(CFG_WR_MASK & wr_bits)) |
					(wdata_reg[15:0] & CFG_WR_MASK & wr_bits);
			end
		end
	end

	// Edge detection on the filtered level, both directions
	assign edge_evt = level_flt ^ level_prev_reg;
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			level_prev_reg <= '0;
		end else begin
			level_prev_reg <= level_flt;
		end
	end

	// Sticky flags, write one to clear, a new edge wins over the clear
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			int_status_reg <= '0;
		end else if (wr_fire && wr_stat_sel && wstrb_reg[0]) begin
			int_status_reg <= (int_status_reg & ~wdata_reg[NUM_PINS-1:0]) | edge_evt;
		end else begin
			int_status_reg <= int_status_reg | edge_evt;
		end
	end

	// Interrupt mask
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			int_mask_reg <= '0;
		end else if (wr_fire && wr_mask_sel && wstrb_reg[0]) begin
			int_mask_reg <= wdata_reg[NUM_PINS-1:0];
		end
	end

	// Level interrupt output
	assign irq_int = |(int_status_reg & int_mask_reg);
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= irq_int;
		end
	end

	// Accessory pulse: each event loads the fixed width, restarting a pulse in progress
	assign acc_pulse = (pulse_cnt_reg != '0);
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			pulse_cnt_reg <= '0;
		end else if (ACCESSORY_EVENT_I) begin
			pulse_cnt_reg <= PULSE_LOAD;
		end else if (acc_pulse) begin
			pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
		end
	end

	// Output function select per pin
	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			unique case (cfg_reg[p][FN_LSB +: FN_W])
				// Pin 1 carries the record clock, others the third interface
				FN_ALT_AUDIO: out_val[p] = ALT_AUDIO_OUT_I[p];
				FN_LOGIC: out_val[p] = cfg_reg[p][BIT_LVL];
				FN_IRQ: out_val[p] = irq_int;
				FN_TEMP_SHUT: out_val[p] = TEMP_SHUTDOWN_I;
				FN_ACC_PULSE: out_val[p] = acc_pulse;
				FN_FLL1_LOCK: out_val[p] = FLL1_LOCK_I;
				FN_FLL2_LOCK: out_val[p] = FLL2_LOCK_I;
				FN_SRC1_LOCK: out_val[p] = SRC1_LOCK_I;
				FN_SRC2_LOCK: out_val[p] = SRC2_LOCK_I;
				FN_DRC1_SIG: out_val[p] = DRC1_SIGNAL_I;
				FN_DRC2_SIG: out_val[p] = DRC2_SIGNAL_I;
				FN_FIFO_ERR: out_val[p] = FIFO_ERROR_I;
				FN_OPCLK: out_val[p] = OPCLK_I;
				FN_TEMP_WARN: out_val[p] = TEMP_WARNING_I;
				FN_DCS_DONE: out_val[p] = DC_SERVO_DONE_I;
				FN_FLL1_CLK: out_val[p] = FLL1_CLK_I;
				FN_FLL2_CLK: out_val[p] = FLL2_CLK_I;
				// Reserved codes stay inactive
				default: out_val[p] = 1'b0;
			endcase
		end
	end

	// Pin drivers: polarity, push-pull or open-drain, direction
	always_ff @(posedge CLOCK_I) begin
		for (int p = 0; p < NUM_PINS; p++) begin
			if (RST_I) begin
				PIN_OUT_O[p] <= 1'b0;
				PIN_OE_O[p] <= 1'b0;
			end else if (cfg_reg[p][BIT_DIR]) begin
				// Input: release the pin
				PIN_OUT_O[p] <= 1'b0;
				PIN_OE_O[p] <= 1'b0;
			end else if (cfg_reg[p][BIT_OD]) begin
				// Open-drain: only pull low
				PIN_OUT_O[p] <= 1'b0;
				PIN_OE_O[p] <= ~(out_val[p] ^ cfg_reg[p][BIT_POL]);
			end else begin
				// Push-pull
				PIN_OUT_O[p] <= out_val[p] ^ cfg_reg[p][BIT_POL];
				PIN_OE_O[p] <= 1'b1;
			end
		end
	end

	// Pull resistors, both requested means neither
	always_ff @(posedge CLOCK_I) begin
		for (int p = 0; p < NUM_PINS; p++) begin
			if (RST_I) begin
				PULLUP_EN_O[p] <= 1'b0;
				PULLDOWN_EN_O[p] <= 1'b0;
			end else begin
				PULLUP_EN_O[p] <= cfg_reg[p][BIT_PU] & ~cfg_reg[p][BIT_PD];
				PULLDOWN_EN_O[p] <= cfg_reg[p][BIT_PD] & ~cfg_reg[p][BIT_PU];
			end
		end
	end

	// Input routing to the alternate interface and button users
	always_ff @(posedge CLOCK_I) begin
		for (int p = 0; p < NUM_PINS; p++) begin
			if (RST_I) begin
				ALT_AUDIO_IN_O[p] <= 1'b0;
				BUTTON_LEVEL_O[p] <= 1'b0;
			end else begin
				ALT_AUDIO_IN_O[p] <= cfg_reg[p][BIT_DIR] &&
					cfg_reg[p][FN_LSB +: FN_W] == FN_ALT_AUDIO && level_flt[p];
				BUTTON_LEVEL_O[p] <= cfg_reg[p][BIT_DIR] &&
					cfg_reg[p][FN_LSB +: FN_W] == FN_LOGIC && level_flt[p];
			end
		end
	end

	// Read decode; an input pin reports its true level, unaffected by polarity
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (ARADDR_I)
			ADDR_PIN1: rd_data[15:0] = cfg_reg[0];
			ADDR_PIN8: rd_data[15:0] = cfg_reg[1];
			ADDR_PIN9: rd_data[15:0] = cfg_reg[2];
			ADDR_PIN10: rd_data[15:0] = cfg_reg[3];
			ADDR_PIN11: rd_data[15:0] = cfg_reg[4];
			ADDR_INT_STATUS: rd_data[NUM_PINS-1:0] = int_status_reg;
			ADDR_INT_MASK: rd_data[NUM_PINS-1:0] = int_mask_reg;
			default: rd_hit = 1'b0;
		endcase
		for (int p = 0; p < NUM_PINS; p++) begin
			if ((p == 0 && ARADDR_I == ADDR_PIN1) || (p == 1 && ARADDR_I == ADDR_PIN8) ||
				(p == 2 && ARADDR_I == ADDR_PIN9) || (p == 3 && ARADDR_I == ADDR_PIN10) ||
				(p == 4 && ARADDR_I == ADDR_PIN11)) begin
				if (cfg_reg[p][BIT_DIR]) begin
					rd_data[BIT_LVL] = level_flt[p];
				end
			end
		end
	end

	// Read channel: one read at a time, registered data
	assign ARREADY_O = !RVALID_O;
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			RVALID_O <= 1'b0;
			RDATA_O <= 32'h0000_0000;
			RRESP_O <= RESP_OKAY;
		end else if (ARVALID_I && !RVALID_O) begin
			RVALID_O <= 1'b1;
			RDATA_O <= rd_data;
			RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (RREADY_I) begin
			RVALID_O <= 1'b0;
		end
	end
endmodule : mfg_gpio_top

// ==== mfg_gpio_sva.sv ====
// Port-level checker for the multi-function pin controller
`timescale 1ns/10ps
module mfg_gpio_sva
	import mfg_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// Bus handshake
	input wire logic AWVALID_I,
	input wire logic AWREADY_O,
	input wire logic WVALID_I,
	input wire logic WREADY_O,
	input wire logic [1:0] BRESP_O,
	input wire logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic [1:0] RRESP_O,
	input wire logic RVALID_O,
	input wire logic RREADY_I,
	// Pins and interrupt
	input wire logic [NUM_PINS-1:0] PIN_IN_I,
	input wire logic [NUM_PINS-1:0] PIN_OUT_O,
	input wire logic [NUM_PINS-1:0] PIN_OE_O,
	input wire logic [NUM_PINS-1:0] PULLUP_EN_O,
	input wire logic [NUM_PINS-1:0] PULLDOWN_EN_O,
	input wire logic [NUM_PINS-1:0] BUTTON_LEVEL_O,
	input wire logic IRQ_O
);
	// Write activity seen over the last three edges
	logic [2:0] wr_hist_reg;
	// Shift in the write request level each cycle
	always_ff @(posedge CLOCK_I) begin
		wr_hist_reg <= {wr_hist_reg[1:0], AWVALID_I | WVALID_I};
	end
	default clocking @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);
	reset_outputs_a:
	assert property (disable iff (1'b0) RST_I |=> !BVALID_O && !RVALID_O && !IRQ_O && PIN_OE_O == '0)
		else $error("outputs not idle after reset");
	write_answer_a:
	assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |=> !BVALID_O ##1 BVALID_O)
		else $error("write response not two edges after capture");
	bresp_hold_a:
	assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped before taken");
	read_answer_a:
	assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read data not one edge after address");
	rdata_hold_a:
	assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O))
		else $error("read data dropped before taken");
	read_upper_a:
	assert property (RVALID_O |-> RDATA_O[31:16] == 16'h0 && ARREADY_O == !RVALID_O)
		else $error("read upper half not zero or ready wrong");
	pull_exclusive_a:
	assert property ((PULLUP_EN_O & PULLDOWN_EN_O) == '0)
		else $error("both resistors enabled");
	button_filter_a:
	assert property ($rose(BUTTON_LEVEL_O[2]) |-> $past(PIN_IN_I[2], 2) && $past(PIN_IN_I[2], 3))
		else $error("input level accepted without a stable pin");
	irq_latched_a:
	assert property (IRQ_O && !AWVALID_I && !WVALID_I && wr_hist_reg == 3'h0 |=> IRQ_O)
		else $error("interrupt dropped without a register write");
	irq_seen_c: cover property ($rose(IRQ_O));
	slverr_seen_c: cover property (RVALID_O && RRESP_O == RESP_SLVERR);
	pulse_seen_c: cover property ($rose(PIN_OUT_O[3]) && PIN_OE_O[3]);
endmodule : mfg_gpio_sva
bind mfg_gpio_top mfg_gpio_sva u_sva (.*);

// ==== mfg_pin_model.sv ====
// Far-side pad model: external drivers, pull resistors and floating pads
`timescale 1ns/10ps
module mfg_pin_model (
	// Clock used only to age floating pads
	input wire logic clk_i,
	// Pad drive from the block
	input wire logic [4:0] pin_out_i,
	input wire logic [4:0] pin_oe_i,
	input wire logic [4:0] pu_i,
	input wire logic [4:0] pd_i,
	// External device drive
	input wire logic [4:0] ext_val_i,
	input wire logic [4:0] ext_en_i,
	// Resolved pad level
	output logic [4:0] pad_o
);
	// Last pad level, so a floating pad keeps changing
	logic [4:0] last_reg = 5'h0;
	// Remember the level every cycle
	always @(posedge clk_i) begin
		last_reg <= pad_o;
	end
	// Resolve each pad: external device, block driver, resistor, then float
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (ext_en_i[i]) begin
				pad_o[i] = ext_val_i[i];
			end else if (pin_oe_i[i]) begin
				pad_o[i] = pin_out_i[i];
			end else if (pu_i[i]) begin
				pad_o[i] = 1'b1;
			end else if (pd_i[i]) begin
				pad_o[i] = 1'b0;
			end else begin
				pad_o[i] = ~last_reg[i];
			end
		end
	end
endmodule : mfg_pin_model

// ==== multi_function_gpio_control_bench.sv ====
// Self-checking bench for the multi-function pin controller
`timescale 1ns/10ps
module multi_function_gpio_control_bench
	import mfg_pkg::*;
;
	// Clock, reset and bus drive
	logic CLOCK_I = 1'b0;
	logic RST_I = 1'b1;
	logic [15:0] AWADDR_I = 16'h0;
	logic [15:0] ARADDR_I = 16'h0;
	logic [31:0] WDATA_I = 32'h0;
	logic [3:0] WSTRB_I = 4'h3;
	logic AWVALID_I = 1'b0;
	logic WVALID_I = 1'b0;
	logic BREADY_I = 1'b0;
	logic ARVALID_I = 1'b0;
	logic RREADY_I = 1'b0;
	// Block outputs
	logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, IRQ_O;
	logic [1:0] BRESP_O, RRESP_O;
	logic [31:0] RDATA_O;
	logic [NUM_PINS-1:0] PIN_OUT_O, PIN_OE_O, PULLUP_EN_O, PULLDOWN_EN_O;
	logic [NUM_PINS-1:0] ALT_AUDIO_IN_O, BUTTON_LEVEL_O, pad;
	// Internal sources and external pad drive
	logic [NUM_PINS-1:0] ALT_AUDIO_OUT_I = 5'h0;
	logic ACCESSORY_EVENT_I = 1'b0;
	logic [12:0] src = 13'h0;
	logic [NUM_PINS-1:0] ext_val = 5'h0;
	logic [NUM_PINS-1:0] ext_en = 5'h0;
	logic [4:0] codes [13] = '{FN_TEMP_SHUT, FN_FLL1_LOCK, FN_FLL2_LOCK, FN_SRC1_LOCK,
		FN_SRC2_LOCK, FN_DRC1_SIG, FN_DRC2_SIG, FN_FIFO_ERR, FN_OPCLK, FN_TEMP_WARN,
		FN_DCS_DONE, FN_FLL1_CLK, FN_FLL2_CLK};
	int fail_count = 0;
	int cmp_count = 0;
	// Clock generator
	always #50 CLOCK_I = ~CLOCK_I;
	// Block under test with a short filter
	mfg_gpio_top #(.DB_CYCLES(4)) u_dut (.*, .PIN_IN_I(pad), .TEMP_SHUTDOWN_I(src[0]),
		.FLL1_LOCK_I(src[1]), .FLL2_LOCK_I(src[2]), .SRC1_LOCK_I(src[3]), .SRC2_LOCK_I(src[4]),
		.DRC1_SIGNAL_I(src[5]), .DRC2_SIGNAL_I(src[6]), .FIFO_ERROR_I(src[7]), .OPCLK_I(src[8]),
		.TEMP_WARNING_I(src[9]), .DC_SERVO_DONE_I(src[10]), .FLL1_CLK_I(src[11]),
		.FLL2_CLK_I(src[12]));
	// External side of the pins
	mfg_pin_model u_pads (.clk_i(CLOCK_I), .pin_out_i(PIN_OUT_O), .pin_oe_i(PIN_OE_O),
		.pu_i(PULLUP_EN_O), .pd_i(PULLDOWN_EN_O), .ext_val_i(ext_val), .ext_en_i(ext_en),
		.pad_o(pad));
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Verdict and stop
	task automatic end_of_test;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	// Let edges pass, then stop mid-cycle where outputs are settled
	task automatic settle(input int n);
		repeat (n) @(posedge CLOCK_I);
		@(negedge CLOCK_I);
	endtask : settle
	// Register index to byte address
	function automatic logic [15:0] ad(input logic [15:0] i);
		return {i[13:0], 2'h0};
	endfunction : ad
	// One bus transfer; readies are sampled mid-cycle and acted on at the next edge
	// The response ready rises only once its valid is seen, so the answer must hold a cycle
	task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [31:0] q, output logic [1:0] rs);
		int n;
		logic ka, kw, kr, kb, rdy;
		rdy = 1'b0;
		@(posedge CLOCK_I);
		AWADDR_I <= a;
		ARADDR_I <= a;
		WDATA_I <= {16'h0, d};
		AWVALID_I <= w;
		WVALID_I <= w;
		ARVALID_I <= !w;
		for (n = 0; n < 50; n++) begin
			@(negedge CLOCK_I);
			ka = AWREADY_O;
			kw = WREADY_O;
			kr = ARREADY_O;
			kb = w ? BVALID_O : RVALID_O;
			q = RDATA_O;
			rs = w ? BRESP_O : RRESP_O;
			@(posedge CLOCK_I);
			if (ka) AWVALID_I <= 1'b0;
			if (kw) WVALID_I <= 1'b0;
			if (kr) ARVALID_I <= 1'b0;
			if (kb && rdy) begin
				// Answer taken at this edge
				BREADY_I <= 1'b0;
				RREADY_I <= 1'b0;
				break;
			end
			if (kb) begin
				// Answer seen: accept it at the next edge
				BREADY_I <= w;
				RREADY_I <= !w;
				rdy = 1'b1;
			end
		end
		if (n == 50) begin
			fail_count++;
			end_of_test();
		end
	endtask : bus
	// Register write and read expecting an OKAY answer
	task automatic wr(input logic [15:0] i, input logic [15:0] d);
		logic [31:0] q;
		logic [1:0] rs;
		bus(1'b1, ad(i), d, q, rs);
		chk("write resp", rs, RESP_OKAY);
	endtask : wr
	task automatic rd(input logic [15:0] i, output logic [31:0] q);
		logic [1:0] rs;
		bus(1'b0, ad(i), 16'h0, q, rs);
		chk("read resp", rs, RESP_OKAY);
	endtask : rd
	// Reset values, pull state and unmapped accesses
	task automatic t_reset;
		logic [15:0] idx [7] = '{IDX_PIN1, IDX_PIN8, IDX_PIN9, IDX_PIN10, IDX_PIN11,
			IDX_INT_STATUS, IDX_INT_MASK};
		logic [31:0] ex [7] = '{32'ha100, 32'ha101, 32'ha101, 32'ha101, 32'ha101, 0, 0};
		logic [31:0] q;
		logic [1:0] rs;
		for (int i = 0; i < 7; i++) begin
			rd(idx[i], q);
			chk("reset value", q, ex[i]);
		end
		chk("reset pulls", {PULLUP_EN_O, PULLDOWN_EN_O}, 10'h01f);
		bus(1'b0, ad(16'h0701), 16'h0, q, rs);
		chk("unmapped read", q, 32'h0);
		chk("unmapped read resp", rs, RESP_SLVERR);
		bus(1'b1, ad(16'h0701), 16'hffff, q, rs);
		chk("unmapped write", rs, RESP_SLVERR);
	endtask : t_reset
	// Logic output, polarity, drive type, reserved codes and pulls on the second pin
	task automatic t_out;
		logic [15:0] cf [8] = '{16'h2041, 16'h2441, 16'h2201, 16'h2241, 16'h2002, 16'h2402,
			16'he101, 16'hc101};
		logic [1:0] ex [8] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h1, 2'h3, 2'h0, 2'h2};
		for (int i = 0; i < 8; i++) begin
			wr(IDX_PIN8, cf[i]);
			settle(2);
			if (i < 6) chk("drive", {PIN_OUT_O[1] & PIN_OE_O[1], PIN_OE_O[1]}, ex[i]);
			else chk("pulls", {PULLUP_EN_O[1], PULLDOWN_EN_O[1]}, ex[i]);
		end
		wr(IDX_PIN8, 16'ha101);
	endtask : t_out
	// Alternate audio both ways on pin 1, then every internal source but the accessory pulse on pin 11
	task automatic t_route;
		wr(IDX_PIN1, 16'h2000);
		@(posedge CLOCK_I);
		ALT_AUDIO_OUT_I <= 5'h01;
		settle(2);
		chk("alt out", PIN_OUT_O[0], 1'b1);
		wr(IDX_PIN1, 16'ha000);
		ext_val[0] <= 1'b1;
		ext_en[0] <= 1'b1;
		settle(8);
		chk("alt in", ALT_AUDIO_IN_O[0], 1'b1);
		for (int i = 0; i < 13; i++) begin
			wr(IDX_PIN11, {11'h100, codes[i]});
			src <= 13'h1 << i;
			settle(2);
			chk("source high", PIN_OUT_O[4], 1'b1);
			@(posedge CLOCK_I);
			src <= 13'h0;
			settle(2);
			chk("source low", PIN_OUT_O[4], 1'b0);
		end
	endtask : t_route
	// One accessory event gives one pulse of fixed length
	task automatic t_pulse;
		int cnt;
		cnt = 0;
		wr(IDX_PIN10, 16'h2005);
		ACCESSORY_EVENT_I <= 1'b1;
		@(posedge CLOCK_I);
		ACCESSORY_EVENT_I <= 1'b0;
		for (int i = 0; i < 400; i++) begin
			@(negedge CLOCK_I);
			if (PIN_OUT_O[3] === 1'b1) cnt++;
		end
		chk("pulse length", cnt, PULSE_CYC);
	endtask : t_pulse
	// Filtered input on pin 9: glitch, level, polarity, both edges, latch, mask
	task automatic t_input;
		logic [31:0] q;
		wr(IDX_INT_STATUS, 16'h001f);
		wr(IDX_INT_MASK, 16'h0004);
		ext_en[2] <= 1'b1;
		ext_val[2] <= 1'b1;
		settle(1);
		@(posedge CLOCK_I);
		ext_val[2] <= 1'b0;
		settle(12);
		chk("glitch", {BUTTON_LEVEL_O[2], IRQ_O}, 2'h0);
		@(posedge CLOCK_I);
		ext_val[2] <= 1'b1;
		settle(12);
		chk("button and irq", {BUTTON_LEVEL_O[2], IRQ_O}, 2'h3);
		wr(IDX_PIN9, 16'h8501);
		rd(IDX_PIN9, q);
		chk("level bit", q[BIT_LVL], 1'b1);
		rd(IDX_INT_STATUS, q);
		chk("status", q, 32'h4);
		wr(IDX_INT_STATUS, 16'h0004);
		settle(2);
		chk("irq cleared", IRQ_O, 1'b0);
		@(posedge CLOCK_I);
		ext_val[2] <= 1'b0;
		settle(12);
		chk("falling edge", IRQ_O, 1'b1);
		wr(IDX_INT_MASK, 16'h0000);
		settle(2);
		rd(IDX_INT_STATUS, q);
		chk("masked", {IRQ_O, q[4:0]}, 6'h04);
		// Interrupt function on pin 11 follows the request line
		wr(IDX_PIN11, 16'h2003);
		settle(2);
		chk("irq pin low", PIN_OUT_O[4], 1'b0);
		wr(IDX_INT_MASK, 16'h0004);
		settle(2);
		chk("irq pin high", {IRQ_O, PIN_OUT_O[4], PIN_OE_O[4]}, 3'h7);
	endtask : t_input
	// Main sequence
	initial begin
		repeat (20) @(posedge CLOCK_I);
		RST_I <= 1'b0;
		t_reset();
		t_out();
		t_route();
		t_pulse();
		t_input();
		end_of_test();
	end
endmodule : multi_function_gpio_control_bench
